// file: design/uport_pin_change.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module uport_pin_change (
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	input wire uport_pkg::addr_t ADDR_I,
	input wire uport_pkg::data_t WR_DATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RD_DATA_O,
	output logic IRQ_O,
	input wire uport_pkg::data_t PORT_PIN_I,
	output logic [7:0] PORT_PIN_O,
	output logic [7:0] PORT_PIN_OE_O
);
	import uport_pkg::*;

	// both channel windows reach the same register
	function automatic logic hits(input addr_t a, input addr_t off);
		hits = (a == off) || (a == (off | CHAN_B_OFFSET));
	endfunction : hits

	data_t pin_change_mask;
	data_t pin_direction_config;
	data_t pending;
	data_t pin_out;
	data_t pin_meta;
	data_t pin_sync;
	data_t pin_prev;
	data_t pin_change;
	data_t shown;
	data_t unmasked;
	data_t global_irq_summary;
	irq_port_config_t irq_port_config;
	logic sync_valid;
	logic [SYNC_STAGES:0] prime;
	logic wr_mask;
	logic wr_dir;
	logic wr_pins;
	logic wr_cfg;
	logic rd_flags;
	data_t next_pending;
	data_t next_rd_data;

	always_comb
	begin
		wr_mask = WR_I && hits(ADDR_I, OFF_PIN_CHANGE);
		wr_dir = WR_I && hits(ADDR_I, OFF_PIN_DIRECTION);
		wr_pins = WR_I && hits(ADDR_I, OFF_PIN_LEVEL_VALUE);
		wr_cfg = WR_I && hits(ADDR_I, OFF_IRQ_PORT_CONFIG);
		rd_flags = RD_I && hits(ADDR_I, OFF_PIN_CHANGE);
	end

	// two-flop synchroniser; a pulse shorter than one clock may be missed
	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end
		else
		begin
			pin_meta <= PORT_PIN_I;
			pin_sync <= pin_meta;
		end
	end

	// previous sample; detection waits until the synchroniser holds real
	// pin levels, so a pin held high through reset gives no false edge
	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pin_prev <= 8'h00;
			prime <= '0;
		end
		else
		begin
			pin_prev <= pin_sync;
			prime <= {prime[SYNC_STAGES-1:0], 1'b1};
		end
	end

	always_comb
	begin
		sync_valid = prime[SYNC_STAGES];
		// only pins configured as inputs report transitions
		pin_change = sync_valid ? ((pin_sync ^ pin_prev) &
			pin_direction_config) : 8'h00;
		unmasked = pending & ~pin_change_mask;
		// masked events are shown only with the visibility bit
		shown = pending & (~pin_change_mask |
			{PIN_COUNT{irq_port_config.masked_flags_visible}});
		global_irq_summary = 8'h00;
		global_irq_summary[SUMMARY_PORT_BIT] = |unmasked;
	end

	// read clears only what was shown, so hidden pending events survive;
	// an edge in the clearing cycle wins over the clear
	always_comb
	begin
		next_pending = pending;
		if (rd_flags)
		begin
			next_pending = pending & ~shown;
		end
		next_pending = next_pending | pin_change;
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pending <= 8'h00;
		end
		else
		begin
			pending <= next_pending;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pin_change_mask <= MASK_RESET;
		end
		else if (wr_mask)
		begin
			pin_change_mask <= WR_DATA_I;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pin_direction_config <= DIRECTION_RESET;
			PORT_PIN_OE_O <= ~DIRECTION_RESET;
		end
		else if (wr_dir)
		begin
			pin_direction_config <= WR_DATA_I;
			PORT_PIN_OE_O <= ~WR_DATA_I;
		end
	end

	// outputs take written bits, input positions keep their old value
	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pin_out <= PIN_OUT_RESET;
		end
		else if (wr_pins)
		begin
			pin_out <= (pin_out & pin_direction_config) |
				(WR_DATA_I & ~pin_direction_config);
		end
	end

	always_comb
	begin
		PORT_PIN_O = pin_out;
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			irq_port_config <= irq_port_config_t'(PORT_CONFIG_RESET);
		end
		else if (wr_cfg)
		begin
			irq_port_config <=
				irq_port_config_t'(WR_DATA_I & PORT_CONFIG_USED);
		end
	end

	// irq follows unmasked pending one cycle later, masked never count
	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			IRQ_O <= 1'b0;
		end
		else
		begin
			IRQ_O <= |unmasked;
		end
	end

	always_comb
	begin
		next_rd_data = 8'h00;
		if (hits(ADDR_I, OFF_PIN_CHANGE))
		begin
			next_rd_data = shown;
		end
		else if (hits(ADDR_I, OFF_PIN_DIRECTION))
		begin
			next_rd_data = pin_direction_config;
		end
		else if (hits(ADDR_I, OFF_PIN_LEVEL_VALUE))
		begin
			// synchronised level of every pin, output or input
			next_rd_data = pin_sync;
		end
		else if (hits(ADDR_I, OFF_IRQ_PORT_CONFIG))
		begin
			next_rd_data = data_t'(irq_port_config);
		end
		else if (hits(ADDR_I, OFF_IRQ_SUMMARY))
		begin
			next_rd_data = global_irq_summary;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			RD_DATA_O <= 8'h00;
		end
		else if (RD_I)
		begin
			RD_DATA_O <= next_rd_data;
		end
		else
		begin
			RD_DATA_O <= 8'h00;
		end
	end

	irq_follow_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		##1 (IRQ_O == $past(|(pending & ~pin_change_mask))))
		else $error("irq does not follow unmasked pending flags");

	edge_flag_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		(|(pin_change & ~pin_change_mask)) && !wr_mask
		|=> ##1 IRQ_O)
		else $error("unmasked input transition raised no irq");

	read_clear_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		rd_flags && (pin_change == 8'h00)
		|=> ((pending & $past(shown)) == 8'h00))
		else $error("flag read left shown bits set");

	hidden_keep_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		rd_flags && !irq_port_config.masked_flags_visible
		|=> ((pending & $past(pending & pin_change_mask)) ==
			$past(pending & pin_change_mask)))
		else $error("masked pending event lost on read");

	unmask_raise_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		wr_mask && (|(pending & ~WR_DATA_I)) ##1 (!rd_flags && !wr_mask)
		|=> IRQ_O)
		else $error("unmasking pending pin raised no irq");

	masked_quiet_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		((pending & ~pin_change_mask) == 8'h00) |=>
		!IRQ_O && (global_irq_summary == 8'h00 ||
			$past(pending & ~pin_change_mask) != 8'h00 ||
			!$stable(pending) || !$stable(pin_change_mask)))
		else $error("masked flags drove irq");

	single_request_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		!rd_flags |=> ((pending & $past(pending)) == $past(pending)))
		else $error("pending flag dropped without a read");

	flags_read_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		rd_flags |=> (RD_DATA_O == $past(shown)))
		else $error("flag read returned wrong data");

	dir_read_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		RD_I && hits(ADDR_I, OFF_PIN_DIRECTION)
		|=> (RD_DATA_O == $past(pin_direction_config)))
		else $error("direction read returned wrong data");

	pin_enable_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		PORT_PIN_OE_O == ~pin_direction_config)
		else $error("output enable disagrees with direction");

	pin_write_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		wr_pins |=> (PORT_PIN_O == (($past(pin_out) &
			$past(pin_direction_config)) |
			($past(WR_DATA_I) & ~$past(pin_direction_config)))))
		else $error("pin write touched an input position");

	input_detect_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		sync_valid && (pin_sync != pin_prev) &&
			((pin_sync ^ pin_prev) & pin_direction_config) != 8'h00
		|=> ((pending & $past(pin_change)) == $past(pin_change)))
		else $error("transition on an input pin not recorded");

	pulse_span_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		$changed(PORT_PIN_I) |-> ##(MIN_PULSE_CYCLES + SYNC_STAGES)
			(pin_sync == $past(PORT_PIN_I, 2)))
		else $error("synchroniser delay differs from two stages");

	new_set_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		1'b1 |=> ((pending & ~$past(pending) &
			~$past(pin_direction_config)) == 8'h00))
		else $error("flag set on an output pin");

	mask_write_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		wr_mask |=> (pin_change_mask == $past(WR_DATA_I)))
		else $error("mask write not taken");

	dir_write_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		wr_dir |=> (pin_direction_config == $past(WR_DATA_I)))
		else $error("direction write not taken");

	cfg_write_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		wr_cfg |=> (data_t'(irq_port_config) ==
			($past(WR_DATA_I) & PORT_CONFIG_USED)))
		else $error("port config write not taken");

	hidden_read_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		rd_flags && !irq_port_config.masked_flags_visible
		|=> ((RD_DATA_O & $past(pin_change_mask)) == 8'h00))
		else $error("masked flag shown while hidden");

	visible_read_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		rd_flags && irq_port_config.masked_flags_visible
		|=> (RD_DATA_O == $past(pending)))
		else $error("visible read hid a pending flag");

	summary_read_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		RD_I && hits(ADDR_I, OFF_IRQ_SUMMARY)
		|=> (RD_DATA_O[SUMMARY_PORT_BIT] ==
			$past(|(pending & ~pin_change_mask))))
		else $error("summary disagrees with unmasked flags");

	read_idle_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		!RD_I |=> (RD_DATA_O == 8'h00))
		else $error("read data outside the read cycle");

	pin_hold_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		!wr_pins |=> $stable(PORT_PIN_O))
		else $error("output pins changed without a write");

	level_read_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		RD_I && hits(ADDR_I, OFF_PIN_LEVEL_VALUE)
		|=> (RD_DATA_O == $past(pin_sync)))
		else $error("pin level read returned wrong data");

	// an edge in the clearing cycle must survive the clear
	event_survive_a: assert property (
		@(posedge CLOCK_I) disable iff (RESET_I)
		rd_flags && (|(pin_change & shown))
		|=> ((pending & $past(pin_change)) == $past(pin_change)))
		else $error("edge in the clearing cycle was lost");
endmodule : uport_pin_change
`default_nettype wire

// file: design/uport_pkg.sv
// Summary of operation
// - flag: input pin, transition; irq also unmasked
// - bit n of each pin register is pin n; summary bit 0 is the port
// - reading change flags clears those shown
// - masked events stay pending, hidden unless visible
// - unmasking a pending pin raises its interrupt
// - visible masked flags never drive irq/summary
// - repeated transitions give one request per pin
// - mask one disables, zero enables
// - mask resets to all ones
// - direction zero output, one input
// - direction resets to all inputs
// - change flags read at both channel addresses
// - change mask written at both channel addresses
// - direction read/write at both channel addresses
// - pin value reads pins, writes outputs only
// - visibility bit one shows masked flags
package uport_pkg;
	localparam int PIN_COUNT = 8;
	localparam int ADDR_W = 7;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [PIN_COUNT-1:0] data_t;

	localparam addr_t CHAN_B_OFFSET = 7'h40;
	localparam addr_t OFF_IRQ_SUMMARY = 7'h38;
	localparam addr_t OFF_IRQ_PORT_CONFIG = 7'h39;
	localparam addr_t OFF_PIN_LEVEL_VALUE = 7'h3C;
	localparam addr_t OFF_PIN_CHANGE = 7'h3D;
	localparam addr_t OFF_PIN_DIRECTION = 7'h3E;

	localparam data_t MASK_RESET = 8'hFF;
	localparam data_t DIRECTION_RESET = 8'hFF;
	localparam data_t PORT_CONFIG_RESET = 8'h00;
	localparam data_t PIN_OUT_RESET = 8'h00;
	localparam data_t PORT_CONFIG_USED = 8'h9F;
	localparam int SUMMARY_PORT_BIT = 0;
	localparam int VIS_BIT = 7;

	localparam int CLOCK_PERIOD_NS = 100;
	localparam int MIN_PULSE_NS = 20;
	localparam int MIN_PULSE_CYCLES_RAW =
		(MIN_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int MIN_PULSE_CYCLES =
		(MIN_PULSE_CYCLES_RAW < 1) ? 1 : MIN_PULSE_CYCLES_RAW;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic masked_flags_visible;
		logic [1:0] reserved_zero;
		logic [4:0] other_config;
	} irq_port_config_t;
endpackage : uport_pkg

// file: verif/uport_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module uport_pin_model (
	input wire logic [7:0] drive_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] out_i,
	output logic [7:0] pin_o
);
	// outside levels change only on clock edges, so each is held a full
	// 100 ns, well above the minimum pulse width
	assign pin_o = (oe_i & out_i) | (~oe_i & drive_i);
endmodule : uport_pin_model
`default_nettype wire

// file: verif/universal_port_pin_change_irq_bench.sv
`timescale 1ns/1ns
`default_nettype none
module universal_port_pin_change_irq_bench;
	import uport_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	addr_t addr = '0;
	data_t wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	data_t drive = 8'h00;
	data_t pins;
	logic [7:0] rdata;
	logic [7:0] pout;
	logic [7:0] poe;
	logic irq;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	uport_pin_change uut (
		.CLOCK_I(clk),
		.RESET_I(rst),
		.ADDR_I(addr),
		.WR_DATA_I(wdata),
		.WR_I(wr),
		.RD_I(rd),
		.RD_DATA_O(rdata),
		.IRQ_O(irq),
		.PORT_PIN_I(pins),
		.PORT_PIN_O(pout),
		.PORT_PIN_OE_O(poe)
	);
	uport_pin_model far (
		.drive_i(drive),
		.oe_i(poe),
		.out_i(pout),
		.pin_o(pins)
	);
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk
	task wr_reg(input addr_t a, input data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask : wr_reg
	// data is valid only in the cycle after the strobe
	task rd_reg(input addr_t a, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(what, exp, rdata);
	endtask : rd_reg
	// irq follows a pin edge four cycles later; six leaves margin
	task pin_set(input data_t d);
		@(posedge clk);
		drive <= d;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask : pin_set
	task test_reset_values;
		rd_reg(7'h3E, 8'hFF, "direction a");
		rd_reg(7'h7E, 8'hFF, "direction b");
		chk("oe reset", 8'h00, poe);
		chk("irq reset", 8'h00, {7'h00, irq});
		$display("test reset values done");
	endtask : test_reset_values
	task test_pending;
		pin_set(8'h01);
		rd_reg(7'h3D, 8'h00, "hidden flag");
		chk("irq masked", 8'h00, {7'h00, irq});
		wr_reg(7'h7D, 8'hFE);
		repeat (3) @(negedge clk);
		chk("irq unmasked", 8'h01, {7'h00, irq});
		rd_reg(7'h78, 8'h01, "summary");
		rd_reg(7'h3D, 8'h01, "flag a");
		rd_reg(7'h7D, 8'h00, "flag b");
		repeat (2) @(negedge clk);
		chk("irq cleared", 8'h00, {7'h00, irq});
		$display("test pending done");
	endtask : test_pending
	task test_repeats;
		wr_reg(7'h3D, 8'h00);
		pin_set(8'h03);
		pin_set(8'h01);
		pin_set(8'h03);
		chk("irq repeat", 8'h01, {7'h00, irq});
		rd_reg(7'h7D, 8'h02, "repeat flag");
		rd_reg(7'h3D, 8'h00, "repeat second");
		chk("irq repeat cleared", 8'h00, {7'h00, irq});
		$display("test repeats done");
	endtask : test_repeats
	task test_visible;
		wr_reg(7'h39, 8'h80);
		wr_reg(7'h3D, 8'h04);
		pin_set(8'h07);
		chk("irq visible", 8'h00, {7'h00, irq});
		rd_reg(7'h38, 8'h00, "summary masked");
		rd_reg(7'h3D, 8'h04, "visible flag");
		rd_reg(7'h79, 8'h80, "port config");
		$display("test visible done");
	endtask : test_visible
	task test_outputs;
		wr_reg(7'h3D, 8'h00);
		wr_reg(7'h3E, 8'h0F);
		chk("oe outputs", 8'hF0, poe);
		wr_reg(7'h3C, 8'hFF);
		chk("out levels", 8'hF0, pout);
		wr_reg(7'h7C, 8'h70);
		repeat (4) @(negedge clk);
		chk("irq outputs", 8'h00, {7'h00, irq});
		rd_reg(7'h3D, 8'h00, "output edge");
		rd_reg(7'h3C, 8'h77, "pin levels");
		rd_reg(7'h7E, 8'h0F, "direction written");
		$display("test outputs done");
	endtask : test_outputs
	// input pins 0 to 2 stay high through this reset; no edge may follow release
	task test_reset_again;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wr_reg(7'h3D, 8'h00);
		repeat (6) @(negedge clk);
		rd_reg(7'h7D, 8'h00, "flags after reset");
		chk("irq after reset", 8'h00, {7'h00, irq});
		rd_reg(7'h3E, 8'hFF, "direction after reset");
		chk("pins after reset", 8'h00, pout);
		$display("test second reset done");
	endtask : test_reset_again
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	always @(posedge clk)
	begin
		cycles++;
		if (cycles >= 2000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		test_reset_values();
		test_pending();
		test_repeats();
		test_visible();
		test_outputs();
		test_reset_again();
		report_and_stop();
	end
endmodule : universal_port_pin_change_irq_bench
`default_nettype wire
